/* core/uwl_axil_wcap.sv */
`timescale 1ns/100ps
module uwl_axil_wcap (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        awvalid,
	output wire logic                        awready,
	input  wire logic [uwl_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic                        wvalid,
	output wire logic                        wready,
	input  wire logic [uwl_pkg::DATA_W-1:0]  wdata,
	input  wire logic [uwl_pkg::STRB_W-1:0]  wstrb,
	uwl_wreq_if.cap                          req
);

	logic                       aw_have_ff;
	logic                       w_have_ff;
	logic                       awready_ff;
	logic                       wready_ff;
	logic [uwl_pkg::ADDR_W-1:0] addr_ff;
	logic [uwl_pkg::DATA_W-1:0] data_ff;
	logic [uwl_pkg::STRB_W-1:0] strb_ff;
	logic                       aw_take;
	logic                       w_take;
	logic                       nxt_aw_have;
	logic                       nxt_w_have;

	// address and data are held separately so they may arrive in either order
	assign aw_take     = awvalid && awready_ff;
	assign w_take      = wvalid && wready_ff;
	assign nxt_aw_have = aw_take || (aw_have_ff && !req.consume);
	assign nxt_w_have  = w_take || (w_have_ff && !req.consume);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			addr_ff    <= '0;
			data_ff    <= '0;
			strb_ff    <= '0;
		end
		else
		begin
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			awready_ff <= !nxt_aw_have;
			wready_ff  <= !nxt_w_have;
			if (aw_take)
				addr_ff <= awaddr;
			if (w_take)
			begin
				data_ff <= wdata;
				strb_ff <= wstrb;
			end
		end
	end

	assign awready     = awready_ff;
	assign wready      = wready_ff;
	assign req.aw_have = aw_have_ff;
	assign req.w_have  = w_have_ff;
	assign req.addr    = addr_ff;
	assign req.data    = data_ff;
	assign req.strb    = strb_ff;

endmodule

/* core/uwl_lut_if.sv */
`timescale 1ns/100ps
interface uwl_lut_if;
	logic                        we;
	logic [uwl_pkg::ENTRY_W-1:0] waddr;
	logic [uwl_pkg::DATA_W-1:0]  wdata;
	logic [uwl_pkg::DATA_W-1:0]  wmask;
	logic [uwl_pkg::ENTRY_W-1:0] raddr;
	logic [uwl_pkg::DATA_W-1:0]  rdata;

	modport ctrl (output we, output waddr, output wdata, output wmask, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input wmask, input raddr, output rdata);
endinterface

/* core/uwl_lut_mem.sv */
`timescale 1ns/100ps
module uwl_lut_mem (
	input  wire logic aclk,
	input  wire logic aresetn,
	uwl_lut_if.mem    lut
);

	logic [uwl_pkg::DATA_W-1:0] entry_q [uwl_pkg::ENTRIES];

	// one register per entry so reset clears the whole table at once
	for (genvar i = 0; i < uwl_pkg::ENTRIES; i++)
	begin : g_entry
		logic [uwl_pkg::DATA_W-1:0] entry_ff;
		logic                       hit;

		assign hit = lut.we && (lut.waddr == uwl_pkg::ENTRY_W'(i));

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				entry_ff <= uwl_pkg::LUT_RST; // RULE_11
			else if (hit)
				entry_ff <= uwl_pkg::merge(entry_ff, lut.wdata, lut.wmask); // RULE_09
		end

		assign entry_q[i] = entry_ff;
	end

	assign lut.rdata = entry_q[lut.raddr]; // RULE_10

endmodule

/* core/uwl_pkg.sv */
package uwl_pkg;

	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int STRB_W    = 4;
	localparam int ENTRY_W   = 6;
	localparam int ENTRIES   = 64;
	localparam int ENTRY_LSB = 2;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_SETUP      = 12'h034;
	localparam logic [ADDR_W-1:0] OFF_UPPER      = 12'h038;
	localparam logic [ADDR_W-1:0] OFF_SIZE_SEL   = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_LUT_OFFSET = 12'h050;
	localparam logic [ADDR_W-1:0] OFF_LUT_DATA   = 12'h054;
	localparam logic [ADDR_W-1:0] OFF_TABLE_BASE = 12'h100;

	// window 3 setup fields
	localparam int               SETUP_SIZE_LSB = 12;
	localparam int               SETUP_PF_BIT   = 3;
	localparam logic [DATA_W-1:0] SETUP_WMASK   = 32'hfffff008;
	localparam logic [DATA_W-1:0] SETUP_RO_VAL  = 32'h00000002;
	localparam logic [DATA_W-1:0] SETUP_RST     = 32'h00000000;

	// upper setup fields
	localparam int               UPPER_EN_BIT = 31;
	localparam logic [DATA_W-1:0] UPPER_WMASK = 32'hffffffff;
	localparam logic [DATA_W-1:0] UPPER_RST   = 32'h00000000;

	// lookup offset and table size select
	localparam logic [DATA_W-1:0] OFFSET_WMASK = 32'h000000ff;
	localparam logic [DATA_W-1:0] OFFSET_RST   = 32'h00000000;
	localparam logic [DATA_W-1:0] SIZE_WMASK   = 32'h00000001;
	localparam logic [DATA_W-1:0] SIZE_RST     = 32'h00000000;
	localparam int               SIZE_32MB_BIT = 0;

	// lookup entry fields
	localparam logic [DATA_W-1:0] LUT_ALWAYS_MASK  = 32'hfe000009;
	localparam logic [DATA_W-1:0] LUT_BASE_LO_MASK = 32'h01ffff00;
	localparam logic [DATA_W-1:0] LUT_RST          = 32'h00000000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_SETUP,
		SEL_UPPER,
		SEL_SIZE,
		SEL_OFFSET,
		SEL_DATA,
		SEL_TABLE
	} uwl_sel_t;

	function automatic logic [DATA_W-1:0] strb_mask(input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < STRB_W; i++)
			m[i*8 +: 8] = {8{strb[i]}};
		return m;
	endfunction

	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [DATA_W-1:0] m
	);
		return (old_v & ~m) | (new_v & m);
	endfunction

endpackage

/* core/uwl_top.sv */
// Overview of operation
// [RULE_01] setup bit 0 reads zero: memory space
// [RULE_02] setup bits 2:1 read fixed 01: 64-bit
// [RULE_03] setup bits 31:12 writable size mask, reset zero
// [RULE_04] upper bits 30:0 writable size mask, reset zero
// [RULE_05] upper bit 31 enables 64-bit base register
// [RULE_06] offset bits 7:0 select entry, reset zero
// [RULE_07] entry access happens on data register access
// [RULE_08] software sets offset before data register access
// [RULE_09] data register write stores selected entry
// [RULE_10] data register read returns selected entry
// [RULE_11] entry valid bit 0, prefetchable bit 3
// [RULE_12] entry bits 24:8 writable in 256B mode
// [RULE_13] entry bits 24:8 read-only in 32MB mode
// [RULE_14] entry bits 31:25 writable; table at 100h-1FFh
// [RULE_15] reserved bits read zero, writes ignored
// [RULE_16] setup bit 3 prefetchable, read/write, reset zero
`timescale 1ns/100ps
module uwl_top (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        s_axi_awvalid,
	output wire logic                        s_axi_awready,
	input  wire logic [uwl_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_wvalid,
	output wire logic                        s_axi_wready,
	input  wire logic [uwl_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [uwl_pkg::STRB_W-1:0]  s_axi_wstrb,
	output wire logic                        s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output wire logic [1:0]                  s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output wire logic                        s_axi_arready,
	input  wire logic [uwl_pkg::ADDR_W-1:0]  s_axi_araddr,
	output wire logic                        s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output wire logic [uwl_pkg::DATA_W-1:0]  s_axi_rdata,
	output wire logic [1:0]                  s_axi_rresp,
	output wire logic [19:0]                 win3_size_mask,
	output wire logic                        win3_prefetch,
	output wire logic [30:0]                 win3_upper_mask,
	output wire logic                        win3_bar64_en,
	output wire logic                        lut_size_32mb
);

	uwl_wreq_if req ();
	uwl_lut_if  lut ();

	logic [uwl_pkg::DATA_W-1:0] setup_ff;
	logic [uwl_pkg::DATA_W-1:0] upper_ff;
	logic [uwl_pkg::DATA_W-1:0] offset_ff;
	logic [uwl_pkg::DATA_W-1:0] size_ff;
	logic                       bvalid_ff;
	logic [1:0]                 bresp_ff;
	logic                       arready_ff;
	logic                       rvalid_ff;
	logic [uwl_pkg::DATA_W-1:0] rdata_ff;
	logic [1:0]                 rresp_ff;

	uwl_pkg::uwl_sel_t          wr_sel;
	uwl_pkg::uwl_sel_t          rd_sel;
	logic                       wr_go;
	logic                       rd_go;
	logic                       wr_lut;
	logic [uwl_pkg::DATA_W-1:0] wr_mask;
	logic [uwl_pkg::DATA_W-1:0] lut_cfg_mask;
	logic [uwl_pkg::DATA_W-1:0] lut_rd_word;
	logic [uwl_pkg::DATA_W-1:0] rd_word;
	logic                       rd_err;
	logic                       wr_err;
	logic                       rd_done;
	logic                       rd_setup;
	logic                       rd_upper;
	logic                       rd_size;
	logic                       rd_offset;
	logic                       rd_lut;
	logic [uwl_pkg::DATA_W-1:0] setup_rd;
	logic                       wr_setup;
	logic                       wr_upper;
	logic                       wr_offset;
	logic                       wr_size;
	logic [uwl_pkg::DATA_W-1:0] nxt_setup;
	logic [uwl_pkg::DATA_W-1:0] nxt_upper;
	logic [uwl_pkg::DATA_W-1:0] nxt_offset;
	logic [uwl_pkg::DATA_W-1:0] nxt_size;
	logic [1:0]                 wr_code;
	logic [1:0]                 rd_code;
	logic                       nxt_bvalid;
	logic [1:0]                 nxt_bresp;
	logic                       nxt_arready;
	logic                       nxt_rvalid;
	logic [uwl_pkg::DATA_W-1:0] nxt_rdata;
	logic [1:0]                 nxt_rresp;

	function automatic uwl_pkg::uwl_sel_t reg_sel(input logic [uwl_pkg::ADDR_W-1:0] a);
		logic [uwl_pkg::ADDR_W-3:0] w;
		w = a[uwl_pkg::ADDR_W-1:2];
		if (a[uwl_pkg::ADDR_W-1:8] == uwl_pkg::OFF_TABLE_BASE[uwl_pkg::ADDR_W-1:8])
			return uwl_pkg::SEL_TABLE;
		else if (w == uwl_pkg::OFF_SETUP[uwl_pkg::ADDR_W-1:2])
			return uwl_pkg::SEL_SETUP;
		else if (w == uwl_pkg::OFF_UPPER[uwl_pkg::ADDR_W-1:2])
			return uwl_pkg::SEL_UPPER;
		else if (w == uwl_pkg::OFF_SIZE_SEL[uwl_pkg::ADDR_W-1:2])
			return uwl_pkg::SEL_SIZE;
		else if (w == uwl_pkg::OFF_LUT_OFFSET[uwl_pkg::ADDR_W-1:2])
			return uwl_pkg::SEL_OFFSET;
		else if (w == uwl_pkg::OFF_LUT_DATA[uwl_pkg::ADDR_W-1:2])
			return uwl_pkg::SEL_DATA;
		else
			return uwl_pkg::SEL_NONE;
	endfunction

	// direct table window uses its own address; the data register uses the held offset
	function automatic logic [uwl_pkg::ENTRY_W-1:0] entry_index(
		input uwl_pkg::uwl_sel_t          s,
		input logic [uwl_pkg::ADDR_W-1:0] a,
		input logic [uwl_pkg::DATA_W-1:0] ofs
	);
		if (s == uwl_pkg::SEL_TABLE)
			return a[uwl_pkg::ENTRY_LSB +: uwl_pkg::ENTRY_W];
		else
			return ofs[uwl_pkg::ENTRY_LSB +: uwl_pkg::ENTRY_W];
	endfunction

	// both the data register and the direct window land in the table
	function automatic logic hits_table(input uwl_pkg::uwl_sel_t s);
		return (s == uwl_pkg::SEL_DATA) || (s == uwl_pkg::SEL_TABLE);
	endfunction

	// unmapped addresses are refused; everything else is accepted
	function automatic logic [1:0] resp_code(input logic err);
		return err ? uwl_pkg::RESP_SLVERR : uwl_pkg::RESP_OKAY;
	endfunction

	uwl_axil_wcap i_uwl_axil_wcap (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.awaddr  (s_axi_awaddr),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.req     (req.cap)
	);

	uwl_lut_mem i_uwl_lut_mem (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lut     (lut.mem)
	);

	// a write waits until both halves are held and the previous response is gone
	assign wr_go       = req.aw_have && req.w_have && !bvalid_ff;
	assign req.consume = wr_go;
	assign wr_sel      = reg_sel(req.addr);
	assign wr_err      = (wr_sel == uwl_pkg::SEL_NONE);
	assign wr_mask     = uwl_pkg::strb_mask(req.strb);
	assign wr_lut      = hits_table(wr_sel);

	// in 32MB mode the low base bits keep their stored value but read as zero
	assign lut_cfg_mask = size_ff[uwl_pkg::SIZE_32MB_BIT] ? uwl_pkg::LUT_ALWAYS_MASK // RULE_13
	                    : (uwl_pkg::LUT_ALWAYS_MASK | uwl_pkg::LUT_BASE_LO_MASK);     // RULE_12

	assign lut.we    = wr_go && wr_lut;                                   // RULE_07
	assign lut.waddr = entry_index(wr_sel, req.addr, offset_ff);          // RULE_14
	assign lut.wdata = req.data;
	assign lut.wmask = lut_cfg_mask & wr_mask;                            // RULE_11

	assign rd_go       = s_axi_arvalid && arready_ff;
	assign rd_done     = rvalid_ff && s_axi_rready;
	assign rd_sel      = reg_sel(s_axi_araddr);
	assign rd_err      = (rd_sel == uwl_pkg::SEL_NONE);
	assign lut.raddr   = entry_index(rd_sel, s_axi_araddr, offset_ff);    // RULE_07
	assign lut_rd_word = lut.rdata & lut_cfg_mask;                        // RULE_15

	assign setup_rd  = setup_ff | uwl_pkg::SETUP_RO_VAL; // RULE_01
	assign rd_setup  = (rd_sel == uwl_pkg::SEL_SETUP);
	assign rd_upper  = (rd_sel == uwl_pkg::SEL_UPPER);
	assign rd_size   = (rd_sel == uwl_pkg::SEL_SIZE);
	assign rd_offset = (rd_sel == uwl_pkg::SEL_OFFSET);
	assign rd_lut    = hits_table(rd_sel);

	assign rd_word = rd_setup  ? setup_rd :
	                 rd_upper  ? upper_ff :
	                 rd_size   ? size_ff :
	                 rd_offset ? offset_ff :
	                 rd_lut    ? lut_rd_word : // RULE_10
	                 '0;

	// one strobe per register; a refused write raises none of them
	assign wr_setup  = wr_go && (wr_sel == uwl_pkg::SEL_SETUP);
	assign wr_upper  = wr_go && (wr_sel == uwl_pkg::SEL_UPPER);
	assign wr_offset = wr_go && (wr_sel == uwl_pkg::SEL_OFFSET);
	assign wr_size   = wr_go && (wr_sel == uwl_pkg::SEL_SIZE);

	// only writable bits are stored, so read-only and reserved bits stay zero
	assign nxt_setup  = wr_setup ? uwl_pkg::merge(setup_ff, req.data, uwl_pkg::SETUP_WMASK & wr_mask) // RULE_02
	                  : setup_ff;
	assign nxt_upper  = wr_upper ? uwl_pkg::merge(upper_ff, req.data, uwl_pkg::UPPER_WMASK & wr_mask) // RULE_05
	                  : upper_ff;
	assign nxt_offset = wr_offset ? uwl_pkg::merge(offset_ff, req.data, uwl_pkg::OFFSET_WMASK & wr_mask) // RULE_15
	                  : offset_ff;
	assign nxt_size   = wr_size ? uwl_pkg::merge(size_ff, req.data, uwl_pkg::SIZE_WMASK & wr_mask)
	                  : size_ff;

	// a response stands until its ready is seen; no new address while read data waits
	assign wr_code     = resp_code(wr_err);
	assign rd_code     = resp_code(rd_err);
	assign nxt_bvalid  = wr_go || (bvalid_ff && !s_axi_bready);
	assign nxt_bresp   = wr_go ? wr_code : bresp_ff;
	assign nxt_arready = !rd_go && (arready_ff || rd_done);
	assign nxt_rvalid  = rd_go || (rvalid_ff && !rd_done);
	assign nxt_rdata   = rd_go ? rd_word : rdata_ff;
	assign nxt_rresp   = rd_go ? rd_code : rresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			setup_ff <= uwl_pkg::SETUP_RST; // RULE_03
		else
			setup_ff <= nxt_setup;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			upper_ff <= uwl_pkg::UPPER_RST; // RULE_04
		else
			upper_ff <= nxt_upper;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			offset_ff <= uwl_pkg::OFFSET_RST; // RULE_06
		else
			offset_ff <= nxt_offset;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			size_ff <= uwl_pkg::SIZE_RST;
		else
			size_ff <= nxt_size;
	end

	// write response channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= uwl_pkg::RESP_OKAY;
		end
		else
		begin
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
		end
	end

	// read handshake: one read in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
		end
		else
		begin
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	// read payload, captured as the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_ff <= '0;
			rresp_ff <= uwl_pkg::RESP_OKAY;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_arready   = arready_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rdata     = rdata_ff;
	assign s_axi_rresp     = rresp_ff;
	assign win3_size_mask  = setup_ff[uwl_pkg::DATA_W-1:uwl_pkg::SETUP_SIZE_LSB];
	assign win3_prefetch   = setup_ff[uwl_pkg::SETUP_PF_BIT]; // RULE_16
	assign win3_upper_mask = upper_ff[uwl_pkg::UPPER_EN_BIT-1:0];
	assign win3_bar64_en   = upper_ff[uwl_pkg::UPPER_EN_BIT];
	assign lut_size_32mb   = size_ff[uwl_pkg::SIZE_32MB_BIT];

endmodule

/* core/uwl_wreq_if.sv */
`timescale 1ns/100ps
interface uwl_wreq_if;
	logic                        aw_have;
	logic                        w_have;
	logic [uwl_pkg::ADDR_W-1:0]  addr;
	logic [uwl_pkg::DATA_W-1:0]  data;
	logic [uwl_pkg::STRB_W-1:0]  strb;
	logic                        consume;

	modport cap (output aw_have, output w_have, output addr, output data, output strb, input consume);
	modport core (input aw_have, input w_have, input addr, input data, input strb, output consume);
endinterface

/* tb/uwl_monitor.sv */
`timescale 1ns/100ps
module uwl_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [19:0] win3_size_mask,
	input wire logic        win3_prefetch,
	input wire logic [30:0] win3_upper_mask,
	input wire logic        win3_bar64_en
);
	logic [11:0] ra_ff;

	// read data is judged per register, so keep the address of the read in flight
	always_ff @(posedge aclk)
		if (!aresetn)
			ra_ff <= 12'h000;
		else if (s_axi_arvalid && s_axi_arready)
			ra_ff <= s_axi_araddr;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_setup_fixed: assert property (s_axi_rvalid && ra_ff == 12'h034 |-> s_axi_rdata[11:0] == {8'h00, s_axi_rdata[3], 3'h2})
		else $error("setup fixed bits wrong");
	a_setup_mirror: assert property (s_axi_rvalid && ra_ff == 12'h034 |->
		s_axi_rdata[31:12] == win3_size_mask && s_axi_rdata[3] == win3_prefetch)
		else $error("setup outputs differ from register");
	a_upper_mirror: assert property (s_axi_rvalid && ra_ff == 12'h038 |-> s_axi_rdata == {win3_bar64_en, win3_upper_mask})
		else $error("upper outputs differ from register");
	a_offset_rsvd: assert property (s_axi_rvalid && ra_ff == 12'h050 |-> s_axi_rdata[31:8] == 24'h0)
		else $error("offset reserved bits not zero");
	a_unmapped_err: assert property (s_axi_rvalid && ra_ff == 12'h044 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule

/* tb/uwl_top_tb.sv */
`timescale 1ns/100ps
module uwl_top_tb;
	logic        aclk;
	logic        aresetn;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [11:0] s_axi_awaddr;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [11:0] s_axi_araddr;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic [19:0] win3_size_mask;
	logic        win3_prefetch;
	logic [30:0] win3_upper_mask;
	logic        win3_bar64_en;
	logic        lut_size_32mb;
	int          error_cnt;
	int          num_checks;
	int          cyc;
	logic [31:0] d;
	logic [1:0]  r;

	uwl_top i_uwl_top (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.s_axi_awvalid   (s_axi_awvalid),
		.s_axi_awready   (s_axi_awready),
		.s_axi_awaddr    (s_axi_awaddr),
		.s_axi_wvalid    (s_axi_wvalid),
		.s_axi_wready    (s_axi_wready),
		.s_axi_wdata     (s_axi_wdata),
		.s_axi_wstrb     (s_axi_wstrb),
		.s_axi_bvalid    (s_axi_bvalid),
		.s_axi_bready    (s_axi_bready),
		.s_axi_bresp     (s_axi_bresp),
		.s_axi_arvalid   (s_axi_arvalid),
		.s_axi_arready   (s_axi_arready),
		.s_axi_araddr    (s_axi_araddr),
		.s_axi_rvalid    (s_axi_rvalid),
		.s_axi_rready    (s_axi_rready),
		.s_axi_rdata     (s_axi_rdata),
		.s_axi_rresp     (s_axi_rresp),
		.win3_size_mask  (win3_size_mask),
		.win3_prefetch   (win3_prefetch),
		.win3_upper_mask (win3_upper_mask),
		.win3_bar64_en   (win3_bar64_en),
		.lut_size_32mb   (lut_size_32mb)
	);

	initial
	begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end

	// under two hundred cycles are needed; the ceiling leaves ample margin
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			$display("unexpected at %0t: run did not finish", $time);
			end_sim;
		end
	end

	task end_sim;
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task wrc(input logic [11:0] a, input logic [31:0] v);
		wr(a, v, 4'hf);
		chk({30'h0, r}, 32'h0);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
		chk({30'h0, r}, 32'h0);
	endtask

	task t_reset;
		rdc(12'h034, 32'h00000002);
		rdc(12'h038, 32'h0);
		rdc(12'h050, 32'h0);
		rdc(12'h054, 32'h0);
		chk({win3_bar64_en, win3_upper_mask}, 32'h0);
		$display("reset values done");
	endtask

	task t_setup;
		wrc(12'h034, 32'hffffffff);
		rdc(12'h034, 32'hfffff00a);
		chk({win3_size_mask, 11'h0, win3_prefetch}, 32'hfffff001);
		wr(12'h034, 32'h0, 4'h1);
		rdc(12'h034, 32'hfffff002);
		wrc(12'h034, 32'h0);
		rdc(12'h034, 32'h00000002);
		wrc(12'h038, 32'h80000005);
		rdc(12'h038, 32'h80000005);
		chk({win3_bar64_en, win3_upper_mask}, 32'h80000005);
		$display("window setup done");
	endtask

	task t_lut;
		logic [7:0]  o;
		logic [31:0] v;
		wrc(12'h050, 32'hffffffff);
		rdc(12'h050, 32'h000000ff);
		// offsets 00, 54, a8, fc reach both ends of the table
		for (int i = 0; i < 4; i++)
		begin
			o = 8'(i * 84);
			wrc(12'h050, {24'h0, o});
			wrc(12'h054, {o, 24'hffffff});
		end
		for (int i = 0; i < 4; i++)
		begin
			o = 8'(i * 84);
			v = {o, 24'hffffff} & 32'hffffff09;
			wrc(12'h050, {24'h0, o + 8'h1});
			rdc(12'h054, v);
			rdc(12'h100 + {4'h0, o}, v);
		end
		$display("lookup table done");
	endtask

	task t_mode;
		wrc(12'h040, 32'h1);
		chk({31'h0, lut_size_32mb}, 32'h1);
		wrc(12'h050, 32'h0);
		rdc(12'h054, 32'h00000009);
		wrc(12'h054, 32'h80000000);
		rdc(12'h054, 32'h80000000);
		wrc(12'h040, 32'h0);
		rdc(12'h054, 32'h80ffff00);
		wrc(12'h1fc, 32'h02000001);
		wrc(12'h050, 32'hfc);
		rdc(12'h054, 32'h02000001);
		rd(12'h044);
		chk({30'h0, r}, 32'h2);
		wr(12'h044, 32'hffffffff, 4'hf);
		chk({30'h0, r}, 32'h2);
		$display("size mode and refusal done");
	endtask

	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		aresetn = 1'h0;
		s_axi_awvalid = 1'h0;
		s_axi_awaddr = 12'h0;
		s_axi_wvalid = 1'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_araddr = 12'h0;
		s_axi_rready = 1'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_setup;
		t_lut;
		t_mode;
		end_sim;
	end
endmodule

bind uwl_top uwl_monitor i_uwl_monitor (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.s_axi_awvalid   (s_axi_awvalid),
	.s_axi_awready   (s_axi_awready),
	.s_axi_wvalid    (s_axi_wvalid),
	.s_axi_wready    (s_axi_wready),
	.s_axi_bvalid    (s_axi_bvalid),
	.s_axi_bready    (s_axi_bready),
	.s_axi_bresp     (s_axi_bresp),
	.s_axi_arvalid   (s_axi_arvalid),
	.s_axi_arready   (s_axi_arready),
	.s_axi_araddr    (s_axi_araddr),
	.s_axi_rvalid    (s_axi_rvalid),
	.s_axi_rready    (s_axi_rready),
	.s_axi_rdata     (s_axi_rdata),
	.s_axi_rresp     (s_axi_rresp),
	.win3_size_mask  (win3_size_mask),
	.win3_prefetch   (win3_prefetch),
	.win3_upper_mask (win3_upper_mask),
	.win3_bar64_en   (win3_bar64_en)
);
